//--- dsm_pkg.sv
package dsm_pkg;

  localparam int DSM_DW = 16;
  localparam int DSM_AW = 5;

  // timing
  localparam longint DSM_CLK_HZ      = 64'd20_000_000;
  localparam longint DSM_TICK_MS     = 64'd10;
  localparam longint DSM_TICK_CYC    = DSM_CLK_HZ / 64'd1000 * DSM_TICK_MS;
  localparam int     DSM_TENTH_TICKS = 10;
  localparam int     DSM_TMIN_TICKS  = 600;
  localparam logic [DSM_DW-1:0] DSM_FAN_TEMP   = 16'h0028;
  localparam logic [DSM_DW-1:0] DSM_ANA_FULL   = 16'h03E8;
  localparam logic [1:0]        DSM_SRC_FIXED  = 2'h0;
  localparam logic [1:0]        DSM_SRC_VOLT   = 2'h1;
  localparam logic [1:0]        DSM_SRC_CURR   = 2'h2;

  // register indices
  localparam int DSM_NCFG = 18;
  localparam logic [DSM_AW-1:0] DSM_R_OC_THR   = 5'h00;
  localparam logic [DSM_AW-1:0] DSM_R_OC_DLY   = 5'h01;
  localparam logic [DSM_AW-1:0] DSM_R_CR1_VAL  = 5'h02;
  localparam logic [DSM_AW-1:0] DSM_R_CR1_WID  = 5'h03;
  localparam logic [DSM_AW-1:0] DSM_R_CR2_VAL  = 5'h04;
  localparam logic [DSM_AW-1:0] DSM_R_CR2_WID  = 5'h05;
  localparam logic [DSM_AW-1:0] DSM_R_TMR_EN   = 5'h06;
  localparam logic [DSM_AW-1:0] DSM_R_TMR_SRC  = 5'h07;
  localparam logic [DSM_AW-1:0] DSM_R_TMR_FIX  = 5'h08;
  localparam logic [DSM_AW-1:0] DSM_R_ANA_LO   = 5'h09;
  localparam logic [DSM_AW-1:0] DSM_R_ANA_HI   = 5'h0A;
  localparam logic [DSM_AW-1:0] DSM_R_TEMP_THR = 5'h0B;
  localparam logic [DSM_AW-1:0] DSM_R_FAN_MODE = 5'h0C;
  localparam logic [DSM_AW-1:0] DSM_R_WAKE_F   = 5'h0D;
  localparam logic [DSM_AW-1:0] DSM_R_WAKE_D   = 5'h0E;
  localparam logic [DSM_AW-1:0] DSM_R_DORM_F   = 5'h0F;
  localparam logic [DSM_AW-1:0] DSM_R_DORM_D   = 5'h10;
  localparam logic [DSM_AW-1:0] DSM_R_RUN_THR  = 5'h11;
  localparam logic [DSM_AW-1:0] DSM_R_STATUS   = 5'h12;
  localparam logic [DSM_AW-1:0] DSM_R_REMAIN   = 5'h13;

  // reset values, in register index order
  localparam logic [DSM_DW-1:0] DSM_CFG_RST [DSM_NCFG] = '{
    16'h07D0, 16'h0000, 16'h03E8, 16'h0000, 16'h03E8, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0136, 16'h02A8, 16'h0064,
    16'h0000, 16'h03E8, 16'h0064, 16'h03E8, 16'h0064, 16'h0000};

  // multifunction output bit positions
  localparam int DSM_MF_OC   = 0;
  localparam int DSM_MF_CR1  = 1;
  localparam int DSM_MF_CR2  = 2;
  localparam int DSM_MF_TMR  = 3;
  localparam int DSM_MF_ANA  = 4;
  localparam int DSM_MF_TEMP = 5;
  localparam int DSM_MF_RUNT = 6;
  localparam int DSM_MF_W    = 7;

  typedef struct packed {
    logic [DSM_DW-1:0] current;
    logic [DSM_DW-1:0] volt_in;
    logic [DSM_DW-1:0] curr_in;
    logic [DSM_DW-1:0] temp;
    logic [DSM_DW-1:0] set_freq;
  } dsm_meas_t;

  typedef enum logic [1:0] {
    DSM_AWAKE, DSM_DORM_WAIT, DSM_DORMANT, DSM_WAKE_WAIT
  } dsm_dorm_t;

endpackage

//--- dsm_top.sv
// Summary of operation
// - Flag overcurrent after current at/above threshold longer than delay.
// - Overcurrent threshold defaults 200.0 percent; zero disables detection.
// - Two comparators flag current within value plus/minus amplitude.
// - Enabled run timer stops drive and flags when duration elapses.
// - Duration source fixed, voltage or current input; full scale is fixed.
// - Timer restarts at each start, counts tenths of a minute, remaining time readable.
// - Flag voltage input above high limit or below low limit.
// - Flag heat-sink temperature reaching threshold, default 100 degrees.
// - Fan mode 0: fan while running; stopped, above 40 on, below off.
// - Fan mode 1: fan always on from power-on.
// - Running, set frequency at/below dormant: stop after dormant delay.
// - Dormant, run command, frequency at/above wakeup: restart after delay.
// - Both frequencies zero disables dormant and wakeup.
// - Flag when running time reaches running-time threshold in tenths of a minute.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module dsm_top
  import dsm_pkg::*;
#(
  parameter longint TICK_CYC = DSM_TICK_CYC
) (
  // clock, reset, enable
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                ce_in,
  // register port
  input  wire logic [DSM_AW-1:0]   addr_in,
  input  wire logic [DSM_DW-1:0]   wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic      [DSM_DW-1:0]   rdata_out,
  // drive core
  input  wire dsm_meas_t           meas_in,
  input  wire logic                running_in,
  input  wire logic                run_cmd_in,
  output logic                     stop_req_out,
  output logic                     start_req_out,
  output logic                     dormant_out,
  output logic                     fan_on_out,
  output logic      [DSM_MF_W-1:0] multifunction_output_out
);

  function automatic logic in_band(input logic [DSM_DW-1:0] cur,
                                   input logic [DSM_DW-1:0] val,
                                   input logic [DSM_DW-1:0] wid);
    logic [DSM_DW:0] lo;
    logic [DSM_DW:0] hi;
    lo = ({1'b0, val} > {1'b0, wid}) ? {1'b0, val} - {1'b0, wid} : '0;
    hi = {1'b0, val} + {1'b0, wid};
    return ({1'b0, cur} >= lo) && ({1'b0, cur} <= hi);
  endfunction

  logic [DSM_DW-1:0] cfg_r [DSM_NCFG];
  logic [DSM_DW-1:0] rdata_r;
  logic [31:0]       tick_cnt_r;
  logic [DSM_DW-1:0] oc_cnt_r;
  logic [9:0]        min_cnt_r;
  logic [DSM_DW-1:0] run_tenths_r;
  logic              running_d_r;
  logic              tmr_done_r;
  logic              fan_r;
  dsm_dorm_t         dstate_r;
  dsm_dorm_t         dstate_nxt;
  logic [DSM_DW-1:0] dcnt_r;
  logic              start_r;
  logic [DSM_MF_W-1:0] mf_r;

  wire logic tick = ce_in && (tick_cnt_r == 32'(TICK_CYC - 1));
  wire logic start_edge = running_in && !running_d_r;
  wire logic cfg_hit = (32'(addr_in) < DSM_NCFG);

  wire logic [DSM_DW-1:0] oc_thr   = cfg_r[DSM_R_OC_THR];
  wire logic [DSM_DW-1:0] oc_dly   = cfg_r[DSM_R_OC_DLY];
  wire logic              tmr_en   = cfg_r[DSM_R_TMR_EN][0];
  wire logic [1:0]        tmr_src  = cfg_r[DSM_R_TMR_SRC][1:0];
  wire logic [DSM_DW-1:0] tmr_fix  = cfg_r[DSM_R_TMR_FIX];
  wire logic              fan_mode = cfg_r[DSM_R_FAN_MODE][0];
  wire logic [DSM_DW-1:0] wake_f   = cfg_r[DSM_R_WAKE_F];
  wire logic [DSM_DW-1:0] dorm_f   = cfg_r[DSM_R_DORM_F];

  wire logic oc_cond = (oc_thr != '0) && (meas_in.current >= oc_thr);

  // analog sources scale the fixed duration
  wire logic [DSM_DW-1:0] ana_sel =
    (tmr_src == DSM_SRC_VOLT) ? meas_in.volt_in : meas_in.curr_in;
  wire logic [31:0] ana_prod = 32'(tmr_fix) * 32'(ana_sel);
  wire logic [31:0] ana_dur  = ana_prod / 32'(DSM_ANA_FULL);
  wire logic [DSM_DW-1:0] tmr_dur =
    (tmr_src == DSM_SRC_FIXED) ? tmr_fix :
    ((tmr_src == DSM_SRC_VOLT) || (tmr_src == DSM_SRC_CURR)) ?
    ((ana_dur > 32'(16'hFFFF)) ? 16'hFFFF : ana_dur[DSM_DW-1:0]) : '0;

  // remaining time in tenths of a minute
  wire logic [DSM_DW-1:0] remain =
    (run_tenths_r >= tmr_dur) ? '0 : tmr_dur - run_tenths_r;
  wire logic tmr_reach = tmr_en && running_in && (run_tenths_r >= tmr_dur);

  wire logic dorm_on = (wake_f != '0) || (dorm_f != '0);
  wire logic dorm_go = running_in && (meas_in.set_freq <= dorm_f);
  wire logic wake_go = run_cmd_in && (meas_in.set_freq >= wake_f);
  wire logic [DSM_DW-1:0] dlim =
    (dstate_r == DSM_WAKE_WAIT) ? cfg_r[DSM_R_WAKE_D] : cfg_r[DSM_R_DORM_D];
  wire logic dcnt_done = (dcnt_r >= dlim);

  always_comb begin
    dstate_nxt = dstate_r;
    if (!dorm_on) begin
      dstate_nxt = DSM_AWAKE;
    end else begin
      unique case (dstate_r)
        DSM_AWAKE: begin
          if (dorm_go) begin
            dstate_nxt = DSM_DORM_WAIT;
          end
        end
        DSM_DORM_WAIT: begin
          if (!dorm_go) begin
            dstate_nxt = DSM_AWAKE;
          end else if (dcnt_done) begin
            dstate_nxt = DSM_DORMANT;
          end
        end
        DSM_DORMANT: begin
          if (!run_cmd_in) begin
            dstate_nxt = DSM_AWAKE;
          end else if (wake_go) begin
            dstate_nxt = DSM_WAKE_WAIT;
          end
        end
        DSM_WAKE_WAIT: begin
          if (!run_cmd_in) begin
            dstate_nxt = DSM_AWAKE;
          end else if (!wake_go) begin
            dstate_nxt = DSM_DORMANT;
          end else if (dcnt_done) begin
            dstate_nxt = DSM_AWAKE;
          end
        end
      endcase
    end
  end

  wire logic fan_hot  = meas_in.temp > DSM_FAN_TEMP;
  wire logic fan_cold = meas_in.temp < DSM_FAN_TEMP;

  wire logic [DSM_MF_W-1:0] mf_nxt = {
    running_in && (run_tenths_r >= cfg_r[DSM_R_RUN_THR]),
    meas_in.temp >= cfg_r[DSM_R_TEMP_THR],
    (meas_in.volt_in > cfg_r[DSM_R_ANA_HI]) ||
      (meas_in.volt_in < cfg_r[DSM_R_ANA_LO]),
    tmr_done_r,
    in_band(meas_in.current, cfg_r[DSM_R_CR2_VAL], cfg_r[DSM_R_CR2_WID]),
    in_band(meas_in.current, cfg_r[DSM_R_CR1_VAL], cfg_r[DSM_R_CR1_WID]),
    oc_cond && (oc_cnt_r > oc_dly)
  };

  wire logic [DSM_DW-1:0] rd_val =
    cfg_hit ? cfg_r[addr_in] :
    (addr_in == DSM_R_STATUS) ? DSM_DW'(mf_r) :
    (addr_in == DSM_R_REMAIN) ? remain : '0;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DSM_NCFG; i++) begin
        cfg_r[i] <= DSM_CFG_RST[i];
      end
      rdata_r <= '0;
    end else if (ce_in) begin
      if (wr_in && cfg_hit) begin
        cfg_r[addr_in] <= wdata_in;
      end
      rdata_r <= rd_in ? rd_val : '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tick_cnt_r <= '0;
    end else if (ce_in) begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 32'h0000_0001;
    end
  end

  // overcurrent duration in 10 ms ticks
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      oc_cnt_r <= '0;
    end else if (ce_in) begin
      if (!oc_cond) begin
        oc_cnt_r <= '0;
      end else if (tick && oc_cnt_r != 16'hFFFF) begin
        oc_cnt_r <= oc_cnt_r + 16'h0001;
      end
    end
  end

  // restart from zero at each start
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      running_d_r  <= 1'b0;
      min_cnt_r    <= '0;
      run_tenths_r <= '0;
    end else if (ce_in) begin
      running_d_r <= running_in;
      if (start_edge) begin
        min_cnt_r    <= '0;
        run_tenths_r <= '0;
      end else if (running_in && tick) begin
        if (min_cnt_r == 10'(DSM_TMIN_TICKS - 1)) begin
          min_cnt_r <= '0;
          if (run_tenths_r != 16'hFFFF) begin
            run_tenths_r <= run_tenths_r + 16'h0001;
          end
        end else begin
          min_cnt_r <= min_cnt_r + 10'h001;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tmr_done_r <= 1'b0;
    end else if (ce_in) begin
      if (start_edge || !tmr_en) begin
        tmr_done_r <= 1'b0;
      end else if (tmr_reach) begin
        tmr_done_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fan_r <= 1'b0;
    end else if (ce_in) begin
      if (fan_mode) begin
        fan_r <= 1'b1;
      end else if (running_in || fan_hot) begin
        fan_r <= 1'b1;
      end else if (fan_cold) begin
        fan_r <= 1'b0;
      end
    end
  end

  // delay counts in 0.1 s steps
  logic [3:0] dsub_r;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dstate_r <= DSM_AWAKE;
      dcnt_r   <= '0;
      dsub_r   <= '0;
      start_r  <= 1'b0;
    end else if (ce_in) begin
      dstate_r <= dstate_nxt;
      start_r  <= (dstate_r == DSM_WAKE_WAIT) && (dstate_nxt == DSM_AWAKE)
                  && run_cmd_in;
      if (dstate_nxt != dstate_r) begin
        dcnt_r <= '0;
        dsub_r <= '0;
      end else if (tick) begin
        if (dsub_r == 4'(DSM_TENTH_TICKS - 1)) begin
          dsub_r <= '0;
          if (dcnt_r != 16'hFFFF) begin
            dcnt_r <= dcnt_r + 16'h0001;
          end
        end else begin
          dsub_r <= dsub_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mf_r <= '0;
    end else if (ce_in) begin
      mf_r <= mf_nxt;
    end
  end

  wire logic is_dorm = (dstate_r == DSM_DORMANT) ||
                       (dstate_r == DSM_WAKE_WAIT);

  assign rdata_out                = rdata_r;
  assign multifunction_output_out = mf_r;
  assign fan_on_out               = fan_r;
  assign dormant_out              = is_dorm;
  assign start_req_out            = start_r;
  assign stop_req_out             = tmr_done_r || is_dorm;

endmodule

//--- dsm_top_asserts.sv
`timescale 1ns/1ps
module dsm_top_asserts
  import dsm_pkg::*;
#(
  parameter longint TICK_CYC = DSM_TICK_CYC
) (
  // clock, reset, enable
  input wire logic                clk_in,
  input wire logic                rst_n_in,
  input wire logic                ce_in,
  // register port
  input wire logic [DSM_AW-1:0]   addr_in,
  input wire logic [DSM_DW-1:0]   wdata_in,
  input wire logic                wr_in,
  input wire logic                rd_in,
  input wire logic [DSM_DW-1:0]   rdata_out,
  // drive core
  input wire dsm_meas_t           meas_in,
  input wire logic                running_in,
  input wire logic                run_cmd_in,
  input wire logic                stop_req_out,
  input wire logic                start_req_out,
  input wire logic                dormant_out,
  input wire logic                fan_on_out,
  input wire logic [DSM_MF_W-1:0] multifunction_output_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // shadow copies of the settings the properties depend on
  logic [DSM_DW-1:0] fan_r, temp_r, lo_r, hi_r;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fan_r  <= DSM_CFG_RST[DSM_R_FAN_MODE];
      temp_r <= DSM_CFG_RST[DSM_R_TEMP_THR];
      lo_r   <= DSM_CFG_RST[DSM_R_ANA_LO];
      hi_r   <= DSM_CFG_RST[DSM_R_ANA_HI];
    end else if (wr_in && ce_in) begin
      if (addr_in == DSM_R_FAN_MODE) fan_r <= wdata_in;
      if (addr_in == DSM_R_TEMP_THR) temp_r <= wdata_in;
      if (addr_in == DSM_R_ANA_LO) lo_r <= wdata_in;
      if (addr_in == DSM_R_ANA_HI) hi_r <= wdata_in;
    end
  end
  wire m0   = (fan_r == 16'h0000);
  wire hot  = (meas_in.temp > DSM_FAN_TEMP);
  wire cold = (meas_in.temp < DSM_FAN_TEMP);
  wire thit = (meas_in.temp >= temp_r);
  wire aout = (meas_in.volt_in > hi_r) || (meas_in.volt_in < lo_r);

  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == '0)
    else $error("read data not idle");
  a_start_pulse: assert property (start_req_out |=> !start_req_out)
    else $error("start request longer than one cycle");
  a_start_dorm: assert property (start_req_out |-> $past(dormant_out))
    else $error("start request without dormancy");
  a_dorm_stop: assert property (dormant_out |-> stop_req_out)
    else $error("dormant without stop request");
  a_fan_always: assert property (fan_r == 16'h0001 |=> fan_on_out)
    else $error("fan off in continuous mode");
  a_fan_run: assert property (m0 && running_in |=> fan_on_out)
    else $error("fan off while running");
  a_fan_hot: assert property (m0 && !running_in && hot |=> fan_on_out)
    else $error("fan off while hot");
  a_fan_cold:
    assert property (m0 && !running_in && cold |=> !fan_on_out)
    else $error("fan on while cool and stopped");
  a_temp_flag:
    assert property ($past(rst_n_in) |->
      multifunction_output_out[DSM_MF_TEMP] == $past(thit))
    else $error("temperature flag wrong");
  a_volt_window:
    assert property ($past(rst_n_in) |->
      multifunction_output_out[DSM_MF_ANA] == $past(aout))
    else $error("voltage window flag wrong");
  c_dormant: cover property ($rose(dormant_out));
  c_wake: cover property (start_req_out);
  c_timer: cover property (multifunction_output_out[DSM_MF_TMR]);
  c_fan_idle: cover property (fan_on_out && !running_in);
endmodule

bind dsm_top dsm_top_asserts #(.TICK_CYC(TICK_CYC)) u_asserts (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .meas_in(meas_in), .running_in(running_in),
  .run_cmd_in(run_cmd_in), .stop_req_out(stop_req_out),
  .start_req_out(start_req_out), .dormant_out(dormant_out),
  .fan_on_out(fan_on_out),
  .multifunction_output_out(multifunction_output_out));

//--- dsm_drive_model.sv
`timescale 1ns/1ps
module dsm_drive_model (
  // clock, reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // supervision side
  input  wire logic run_cmd_in,
  input  wire logic stop_req_in,
  input  wire logic start_req_in,
  output logic      running_out
);
  logic cmd_r, stop_r;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cmd_r       <= 1'b0;
      stop_r      <= 1'b0;
      running_out <= 1'b0;
    end else begin
      cmd_r  <= run_cmd_in;
      stop_r <= stop_req_in;
      // stop is edge taken so a fresh run command can restart the drive
      if (!run_cmd_in || (stop_req_in && !stop_r)) running_out <= 1'b0;
      else if (start_req_in || !cmd_r) running_out <= 1'b1;
    end
  end
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
  import dsm_pkg::*;
  localparam int TMIN  = 6000;
  localparam int TENTH = 100;
  typedef struct packed {
    logic [15:0] cur, volt, temp;
    logic [6:0]  mf;
    logic        fan;
  } dsm_row_t;
  dsm_row_t rows [7] = '{
    '{16'h0000, 16'h01F4, 16'h0019, 7'h00, 1'b0},
    '{16'h03E8, 16'h01F4, 16'h0019, 7'h06, 1'b0},
    '{16'h07D0, 16'h01F4, 16'h0064, 7'h21, 1'b1},
    '{16'h0000, 16'h02A9, 16'h0063, 7'h10, 1'b1},
    '{16'h0000, 16'h0135, 16'h001E, 7'h10, 1'b0},
    '{16'h0000, 16'h0136, 16'h0027, 7'h00, 1'b0},
    '{16'h0000, 16'h02A8, 16'h0032, 7'h00, 1'b1}};
  logic clk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1;
  logic wr_in = 1'b0, rd_in = 1'b0, run_cmd_in = 1'b0;
  logic [DSM_AW-1:0] addr_in = '0;
  logic [DSM_DW-1:0] wdata_in = '0, rdata_out, d;
  dsm_meas_t meas_in = '0;
  logic running_in, stop_req_out, start_req_out, dormant_out, fan_on_out;
  logic [DSM_MF_W-1:0] mf;
  int fails = 0, n_tests = 0, n, bad, ex;

  always #25 clk_in = ~clk_in;

  dsm_top #(.TICK_CYC(64'd10)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .meas_in(meas_in),
    .running_in(running_in), .run_cmd_in(run_cmd_in),
    .stop_req_out(stop_req_out), .start_req_out(start_req_out),
    .dormant_out(dormant_out), .fan_on_out(fan_on_out),
    .multifunction_output_out(mf));
  dsm_drive_model drive (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .run_cmd_in(run_cmd_in), .stop_req_in(stop_req_out),
    .start_req_in(start_req_out), .running_out(running_in));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [DSM_DW-1:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, exp);
    n_tests++;
    if (got < exp - 40 || got > exp + 40) begin
      fails++;
      $display("CHECK FAILED t=%0t took %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [DSM_AW-1:0] a, input logic [DSM_DW-1:0] v);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [DSM_AW-1:0] a, output logic [DSM_DW-1:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  // 0 stop request, 1 dormant, 2 start pulse
  task automatic wait_for(input int sel, output int cnt);
    cnt = 0;
    #1;
    while ((sel == 0 ? stop_req_out : sel == 1 ? dormant_out
            : start_req_out) !== 1'b1) begin
      @(posedge clk_in);
      #1 cnt++;
      if (cnt > 15000) begin
        fails++;
        $display("CHECK FAILED t=%0t wait timed out", $time);
        stop_test();
      end
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    meas_in.set_freq <= 16'h1388;
    for (int i = 0; i < DSM_NCFG; i++) begin
      rd(DSM_AW'(i), d);
      chk(d, DSM_CFG_RST[i]);
    end
    wr(5'h14, 16'h1234);
    rd(5'h14, d);
    chk(d, 16'h0000);
    foreach (rows[i]) begin
      @(posedge clk_in);
      meas_in.current <= rows[i].cur;
      meas_in.volt_in <= rows[i].volt;
      meas_in.temp    <= rows[i].temp;
      repeat (40) @(posedge clk_in);
      #1 chk(16'(mf), 16'(rows[i].mf));
      chk(16'(fan_on_out), 16'(rows[i].fan));
    end
    // overcurrent off at zero threshold, then a delayed trip
    wr(DSM_R_OC_THR, 16'h0000);
    meas_in.current <= 16'h09C4;
    meas_in.temp    <= 16'h0019;
    repeat (40) @(posedge clk_in);
    #1 chk(16'(mf[DSM_MF_OC]), 16'h0000);
    @(posedge clk_in);
    meas_in.current <= 16'h0000;
    wr(DSM_R_OC_DLY, 16'h0005);
    wr(DSM_R_OC_THR, 16'h07D0);
    meas_in.current <= 16'h07D0;
    repeat (45) @(posedge clk_in);
    #1 chk(16'(mf[DSM_MF_OC]), 16'h0000);
    repeat (45) @(posedge clk_in);
    #1 chk(16'(mf[DSM_MF_OC]), 16'h0001);
    @(posedge clk_in);
    meas_in.current <= 16'h0000;
    wr(DSM_R_FAN_MODE, 16'h0001);
    repeat (3) @(posedge clk_in);
    #1 chk(16'(fan_on_out), 16'h0001);
    wr(DSM_R_FAN_MODE, 16'h0000);
    run_cmd_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    #1 chk(16'({running_in, fan_on_out, mf[DSM_MF_RUNT]}), 16'h0007);
    // run timer over every duration source
    wr(DSM_R_TMR_FIX, 16'h0002);
    wr(DSM_R_RUN_THR, 16'h0001);
    wr(DSM_R_TMR_EN, 16'h0001);
    meas_in.volt_in <= 16'h01F4;
    meas_in.curr_in <= 16'h01F4;
    for (int s = 0; s < 4; s++) begin
      wr(DSM_R_TMR_SRC, 16'(s));
      run_cmd_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      run_cmd_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      if (s == 0) rd(DSM_R_REMAIN, d);
      if (s == 0) chk(d, 16'h0002);
      if (s == 0) chk(16'(mf[DSM_MF_RUNT]), 16'h0000);
      ex = (s == 0) ? 2 * TMIN : (s == 3) ? 0 : TMIN;
      wait_for(0, n);
      chk_near(n, ex);
      if (s == 0) chk(16'(mf[DSM_MF_RUNT]), 16'h0001);
      repeat (2) @(posedge clk_in);
      #1 chk(16'(mf[DSM_MF_TMR]), 16'h0001);
      if (s < 3) chk(16'(running_in), 16'h0000);
    end
    // dormancy and wakeup
    wr(DSM_R_TMR_EN, 16'h0000);
    run_cmd_in <= 1'b0;
    wr(DSM_R_DORM_D, 16'h0002);
    wr(DSM_R_WAKE_D, 16'h0003);
    run_cmd_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    meas_in.set_freq <= 16'h01F4;
    wait_for(1, n);
    chk_near(n, 2 * TENTH);
    repeat (2) @(posedge clk_in);
    #1 chk(16'({running_in, stop_req_out}), 16'h0001);
    @(posedge clk_in);
    meas_in.set_freq <= 16'h05DC; // set frequency moves while dormant
    wait_for(2, n);
    chk_near(n, 3 * TENTH);
    repeat (2) @(posedge clk_in);
    #1 chk(16'({running_in, dormant_out}), 16'h0002);
    wr(DSM_R_DORM_F, 16'h0000);
    wr(DSM_R_WAKE_F, 16'h0000);
    meas_in.set_freq <= 16'h0000;
    bad = 0;
    repeat (400) begin
      @(posedge clk_in);
      #1 if (dormant_out !== 1'b0) bad++;
    end
    chk(16'(bad), 16'h0000);
    // mid-run reset: outputs clear, settings back to defaults
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1 chk(16'({stop_req_out, start_req_out, dormant_out}), 16'h0000);
    chk(16'({fan_on_out, mf}), 16'h0000);
    rd(DSM_R_DORM_F, d);
    chk(d, DSM_CFG_RST[DSM_R_DORM_F]);
    stop_test();
  end
endmodule
